// *** logic/jk_multi.v ***
/*
 * multi-input jk storage element, modelled on clk_sys.
 * element clock, j/k and direct inputs arrive from pins and are
 * synchronised here; set/preset together with reset clears the state,
 * drives q and q_n high and is flagged on direct_conflict.
 */
`timescale 1ns/1ps
`include "jk_multi_regs.vh"
module jk_multi #(
  parameter N_IN = `JK_DATA_INPUTS
) (
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  input wire jk_clk,
  input wire [N_IN-1:0] j_in,
  input wire [N_IN-1:0] k_in,
  input wire set_n,
  input wire preset_n,
  input wire reset_n,
  output reg q,
  output reg q_n,
  output reg direct_conflict
);
  localparam W = 2 * N_IN + 4;
  // direct inputs idle high, everything else idles low
  localparam [W-1:0] SYNC_RESET = {{(W-3){1'b0}}, 3'b111};

  wire [W-1:0] pins_s;
  reg clk_d;
  reg cap_j;
  reg cap_k;
  reg armed;
  reg state;
  reg next_state;

  sync_bank #(
    .WIDTH(W),
    .RESET_VALUE(SYNC_RESET)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .async_in({jk_clk, j_in, k_in, set_n, preset_n, reset_n}),
    .sync_out(pins_s)
  );

  wire clk_s = pins_s[W-1];
  wire [N_IN-1:0] j_s = pins_s[W-2:N_IN+3];
  wire [N_IN-1:0] k_s = pins_s[N_IN+2:3];
  wire set_act = ~pins_s[`JK_POS_SET];
  wire preset_act = ~pins_s[`JK_POS_PRESET];
  wire reset_act = ~pins_s[`JK_POS_RESET];
  wire hi_force = set_act | preset_act;
  wire clk_rise = clk_s & ~clk_d;
  wire clk_fall = ~clk_s & clk_d;
  wire j_eff = &j_s; // see RL8
  wire k_eff = &k_s; // see RL8

  // jk table with the present state fed back internally
  always @* begin
    next_state = state;
    case ({cap_j, cap_k})
      2'b00: next_state = state; // see RL9
      2'b01: next_state = 1'b0; // see RL9
      2'b10: next_state = 1'b1; // see RL9
      2'b11: next_state = ~state; // see RL4 see RL9
      default: next_state = state;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      clk_d <= 1'b0;
      cap_j <= 1'b0;
      cap_k <= 1'b0;
      armed <= 1'b0;
      state <= `JK_STATE_RESET;
      q <= `JK_STATE_RESET;
      q_n <= ~`JK_STATE_RESET;
      direct_conflict <= 1'b0;
    end else if (ce) begin
      clk_d <= clk_s;
      // j/k frozen once the clock is high
      if (clk_rise) begin
        cap_j <= j_eff; // see RL5 see RL10
        cap_k <= k_eff; // see RL5 see RL10
        armed <= 1'b1;
      end else if (clk_fall) begin
        armed <= 1'b0;
      end
      // direct inputs win over any clock edge
      if (reset_act) begin
        state <= 1'b0; // see RL2
      end else if (hi_force) begin
        state <= 1'b1; // see RL2
      end else if (clk_fall && armed) begin
        state <= next_state; // see RL1
      end
      // outputs follow the stored state unless forced
      if (hi_force || reset_act) begin
        q <= hi_force; // see RL3
        q_n <= reset_act; // see RL3
      end else if (clk_fall && armed) begin
        q <= next_state;
        q_n <= ~next_state;
      end else begin
        q <= state;
        q_n <= ~state;
      end
      direct_conflict <= hi_force & reset_act;
    end
  end
endmodule

// *** logic/jk_multi_regs.vh ***
// Function
// RL1: state changes only on element clock fall
// RL2: direct inputs act regardless of element clock
// RL3: low direct input drives its output high
// RL4: complement feedback built in, all inputs data
// RL5: clock high blocks further j/k changes
// RL6: downstream decodes outputs on next clock rise
// RL7: counters gate carries through anded inputs
// RL8: effective j and k are three-input ands
// RL9: jk table: hold, clear, set, toggle
// RL10: j/k taken on rise, applied on fall
// RL11: never assert set or preset with reset; the bench asserts set with reset once, raising direct_conflict
/*
 * constants shared by the multi-input jk element.
 * assumes inclusion by bare name from files under logic/.
 */
`ifndef JK_MULTI_REGS_VH
`define JK_MULTI_REGS_VH

`define JK_DATA_INPUTS 3
`define JK_SYNC_STAGES 2
`define JK_STATE_RESET 1'b0
`define JK_BUS_WIDTH 10
`define JK_POS_CLK 9
`define JK_POS_J 6
`define JK_POS_K 3
`define JK_POS_SET 2
`define JK_POS_PRESET 1
`define JK_POS_RESET 0

`endif

// *** logic/sync_bank.v ***
/*
 * two-flop synchroniser bank, one chain per bit.
 * assumes every input bit is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module sync_bank #(
  parameter WIDTH = 10,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : chain
      reg stage_a;
      reg stage_b;
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          stage_a <= RESET_VALUE[i];
          stage_b <= RESET_VALUE[i];
        end else if (ce) begin
          stage_a <= async_in[i];
          stage_b <= stage_a;
        end
      end
      assign sync_out[i] = stage_b;
    end
  endgenerate
endmodule

// *** dv/jk_multi_properties.sv ***
/* jk_multi checker; assumes the design's port names */
`timescale 1ns/1ps
module jk_multi_properties #(parameter N_IN = 3) (input wire clk_sys,
  rst_b, ce, jk_clk, set_n, preset_n, reset_n, q, q_n, direct_conflict,
  input wire [N_IN-1:0] j_in, k_in);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire r = reset_n & ce;
  wire ok = r & set_n & preset_n;
  a_set_wins: assert property ((!set_n & r)[*3] |=> q & !q_n)
    else $error("set");
  a_preset_wins: assert property ((!preset_n & r)[*3] |=> q)
    else $error("preset");
  a_reset_wins: assert property (
    (set_n & preset_n & ce & !reset_n)[*3] |=> !q & q_n) else $error("reset");
  a_out_comp: assert property (ok[*3] |=> q_n != q & !direct_conflict)
    else $error("q_n");
  a_high_hold: assert property (
    ok[*2] ##1 (ok & jk_clk)[*3] |=> $stable(q)) else $error("hold");
  a_ce_freeze: assert property (
    !ce |=> $stable({q, q_n, direct_conflict})) else $error("ce");
  a_jk_table: assert property (!jk_clk ##1 (ok & jk_clk &
    $stable({j_in, k_in}))[*4] ##1 (ok & !jk_clk)[*4] |=>
    q == (&$past(j_in, 5) ? !(&$past(k_in, 5) & $past(q, 4)) :
    !(&$past(k_in, 5)) & $past(q, 4))) else $error("jk");
  c_toggle: cover property (ok & $fell(q));
  c_clash: cover property (direct_conflict);
  c_set: cover property ($rose(q));
  c_freeze: cover property (!ce ##1 ce);
endmodule
bind jk_multi jk_multi_properties #(.N_IN(N_IN)) i_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .jk_clk(jk_clk),
  .set_n(set_n), .preset_n(preset_n), .reset_n(reset_n), .q(q), .q_n(q_n),
  .direct_conflict(direct_conflict), .j_in(j_in), .k_in(k_in));

// *** dv/jk_source.sv ***
/* neighbour stage driving the jk pins; one clock pulse per go */
`timescale 1ns/1ps
module jk_source (input wire clk_sys, go, input wire [5:0] jk,
  output reg jk_clk = 0, busy = 0, output reg [2:0] j_in = 0, k_in = 0);
  reg [3:0] n = 0;
  always @(posedge clk_sys) begin
    n <= busy ? n + 4'h1 : 4'h0;
    jk_clk <= busy & n > 4'h1 & n < 4'h6;
    busy <= busy ? n < 4'hd : go;
    if (!busy)
      {j_in, k_in} <= jk; // data moves only with clock low
  end
endmodule

// *** dv/multi_input_jk_flip_flop_test.sv ***
/* jk_multi bench; clock and j/k pins come from jk_source, direct pins from spr */
`timescale 1ns/1ps
module multi_input_jk_flip_flop_test;
  reg clk_sys = 0, rst_b = 0, go = 0, m = 0, ce = 1;
  reg [2:0] spr = 3'h7;
  reg [5:0] jk = 6'h00;
  wire jk_clk, busy, q, q_n, direct_conflict;
  wire [2:0] j_in, k_in;
  integer n_mismatch = 0, num_checks = 0, i, t;
  jk_multi i_jk_multi (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .jk_clk(jk_clk), .j_in(j_in), .k_in(k_in), .set_n(spr[2]),
    .preset_n(spr[1]), .reset_n(spr[0]), .q(q), .q_n(q_n),
    .direct_conflict(direct_conflict));
  jk_source i_jk_source (.clk_sys(clk_sys), .go(go), .jk(jk),
    .jk_clk(jk_clk), .busy(busy), .j_in(j_in), .k_in(k_in));
  initial forever #2.5 clk_sys = ~clk_sys;
  function expect_q(input [5:0] v, input cur);
    begin
      // jk table over the anded j and k groups
      case ({&v[5:3], &v[2:0]})
        2'b00: expect_q = cur;
        2'b01: expect_q = 1'h0;
        2'b10: expect_q = 1'h1;
        default: expect_q = !cur;
      endcase
    end
  endfunction
  task report_and_stop;
    begin
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task settle(input integer c, input [2:0] x);
    begin
      repeat (c) @(posedge clk_sys);
      #1 num_checks = num_checks + 1;
      if ({q, q_n, direct_conflict} !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: %h %h", $time,
          {q, q_n, direct_conflict}, x);
      end
      @(posedge clk_sys);
    end
  endtask
  task direct(input [2:0] s, x);
    begin
      spr <= s;
      settle(3, x);
      spr <= 3'h7;
      m = s[0];
      settle(3, {m, !m, 1'h0});
    end
  endtask
  task pulse(input [5:0] v);
    begin
      jk <= v;
      go <= 1'h1;
      @(posedge clk_sys) go <= 1'h0;
      m = expect_q(v, m);
      for (i = 0; i < 30 && (i < 2 || busy); i = i + 1) @(posedge clk_sys);
      if (busy) begin
        n_mismatch = n_mismatch + 1;
        report_and_stop;
      end
      settle(0, {m, !m, 1'h0});
    end
  endtask
  initial begin
    i = $urandom(14);
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'h1;
    settle(1, 3'h2);
    direct(3'h3, 3'h4);
    direct(3'h5, 3'h4);
    direct(3'h6, 3'h2);
    direct(3'h2, 3'h7);
    // enable low: a set on the pins must wait for ce
    ce <= 1'h0;
    spr <= 3'h3;
    settle(5, 3'h2);
    ce <= 1'h1;
    settle(3, 3'h4);
    spr <= 3'h7;
    m = 1'h1;
    settle(3, 3'h4);
    for (t = 0; t < 24; t = t + 1)
      pulse(t == 0 ? 6'h38 : t < 3 ? 6'h3f :
        t == 3 ? 6'h07 : 6'($urandom));
    report_and_stop;
  end
endmodule
